// >>> hdl/muting_defs.svh
/*
 * Register map, field positions, reset values and timing figures of the
 * muting sequence monitor.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef MUTING_DEFS_SVH
`define MUTING_DEFS_SVH

`define ADDR_CTRL        12'h000
`define ADDR_MAX_MUTE    12'h004
`define ADDR_SYNC_TIME   12'h008
`define ADDR_STATUS      12'h00C

`define CTRL_RUN_BIT     0
`define CTRL_MODE_BIT    1
`define CTRL_OVR_DUAL    2
`define CTRL_RESET       3'h0

`define MAX_MUTE_W       8
`define MAX_MUTE_RESET   8'h78
`define SYNC_W           16
`define SYNC_RESET       16'h0BB8

`define ST_OUT_EN        0
`define ST_MUTING        1
`define ST_SEQ_ERR       2
`define ST_SYNC_ERR      3
`define ST_LC_DISC       4
`define ST_OVR_DISC      5
`define ST_FAULT         6
`define ST_STATE_LSB     8

`define CLK_HZ           10000000
`define SCAN_TIME_US     1000
`define MUTE_STEP_MS     500
`define SYNC_DEFAULT_MS  3000
`define MUTE_CNT_W       24

`define PIN_W            9
`define SYNC_STAGES      2

`endif

// >>> hdl/muting_pkg.sv
/*
 * Types shared by the muting sequence monitor.
 * Assumes nothing of its surroundings.
 */
package muting_pkg;

	typedef enum logic [2:0] {
		WAIT_CLEAR,
		ARMED,
		SYNCING,
		MUTING,
		HALTED
	} mute_state_t;

	typedef enum logic {
		PARALLEL_TWO,
		SEQ_FORWARD
	} mute_mode_t;

	typedef struct packed {
		logic entry_first;
		logic entry_second;
		logic exit_first;
		logic exit_second;
		logic valid;
	} sensor_set_t;

	typedef struct packed {
		logic [1:0] light_curtain_input_pair;
		logic       lc_discrepancy;
		logic       ovr_discrepancy;
	} guard_set_t;

endpackage

// >>> hdl/muting_sequence_monitor.sv
/*
 * Muting sequence monitor for a light-curtain safety function: parallel
 * two-sensor and sequential forward muting, APB register slave.
 * Assumes asynchronous sensor and curtain pins (synchronised here), an
 * upstream discrepancy checker, and an APB master on mclk.
 */
`timescale 1ns/10ps
`include "muting_defs.svh"

// Behaviour
// - Parallel mode: first sensor on, then second, starts muting.
// - Output enable stays on during muting despite an obstructed curtain.
// - Parallel mode: muting clears when first sensor stops detecting.
// - Start only with curtain active and no discrepancy error.
// - Both sensors off first, then normal order within synchronization time.
// - Wrong order of sensor turn-on raises the sequence error.
// - Sensor spacing beyond the synchronization time raises the synchronization error.
// - Curtain inactive before muting drops output enable.
// - Parallel mode: either sensor going off ends muting.
// - Muting ends once the maximum muting time has elapsed.
// - Curtain obstructed when muting ends drops output enable too.
// - Curtain or dual override discrepancy drops muting and output enable.
// - Muting restarts whenever the start conditions hold again.
// - Synchronization time defaults to 3 s; floor is one scan.
// - Forward mode: second entry first, or both together, is sequence error.
// - Forward mode: exit sensor on at entry detection is sequence error.
// - Synchronization limit expiring before second entry sensor is an error.
// - Forward mode: fewer than two sensors on ends muting.
// - Forward mode: invalid sensor status ends muting.
// - Forward mode: first exit sensor losing the workpiece ends muting.
// - Interruption length is not timed; only maximum muting time is.
// - Maximum muting time 500 ms steps up to 127.5 s; zero unlimited.
// - Synchronization error clears when normal muting is next entered.
// - Sequence error clears only on an idle to run change.
module muting_sequence_monitor #(
	parameter int SCAN_CYCLES = (`CLK_HZ / 1000000) * `SCAN_TIME_US,
	parameter int STEP_SCANS  = (`MUTE_STEP_MS * 1000) / `SCAN_TIME_US
)(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        entry_sensor_first,
	input  wire logic        entry_sensor_second,
	input  wire logic        exit_sensor_first,
	input  wire logic        exit_sensor_second,
	input  wire logic        sensor_status_valid,
	input  wire logic [1:0]  light_curtain_input_pair,
	input  wire logic        lc_discrepancy_err,
	input  wire logic        ovr_discrepancy_err,
	output logic             output_enable,
	output logic             muting_status,
	output logic             sequence_error,
	output logic             sync_error,
	output logic             fault_present
);

	// Pin synchronisers
	logic [`PIN_W-1:0] pin_raw;
	logic [`PIN_W-1:0] meta_q;
	logic [`PIN_W-1:0] pin_s_q;

	assign pin_raw = {entry_sensor_first, entry_sensor_second,
		exit_sensor_first, exit_sensor_second, sensor_status_valid,
		light_curtain_input_pair, lc_discrepancy_err, ovr_discrepancy_err};

	genvar gi;
	generate
		for (gi = 0; gi < `PIN_W; gi++)
		begin : g_sync
			always_ff @(posedge mclk)
			begin
				if (srst)
				begin
					meta_q[gi]  <= 1'b0;
					pin_s_q[gi] <= 1'b0;
				end
				else
				begin
					meta_q[gi]  <= pin_raw[gi];
					pin_s_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	// Scan divider
	logic [31:0] div_q;
	logic        scan_tick_q;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			div_q       <= 32'h0;
			scan_tick_q <= 1'b0;
		end
		else if (div_q >= 32'(SCAN_CYCLES - 1))
		begin
			div_q       <= 32'h0;
			scan_tick_q <= 1'b1;
		end
		else
		begin
			div_q       <= div_q + 32'h1;
			scan_tick_q <= 1'b0;
		end
	end

	// Scan-held input image
	muting_pkg::sensor_set_t sens_q;
	muting_pkg::sensor_set_t sens_prev_q;
	muting_pkg::guard_set_t  guard_q;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			sens_q      <= '0;
			sens_prev_q <= '0;
			guard_q     <= '0;
		end
		else if (scan_tick_q)
		begin
			sens_prev_q <= sens_q;
			sens_q      <= muting_pkg::sensor_set_t'(pin_s_q[8:4]);
			guard_q     <= muting_pkg::guard_set_t'(pin_s_q[3:0]);
		end
	end

	// Scan evaluation strobe, one cycle after the sample
	logic eval_q;

	always_ff @(posedge mclk)
	begin
		if (srst)
			eval_q <= 1'b0;
		else
			eval_q <= scan_tick_q;
	end

	// Registers
	logic [2:0]            ctrl_q;
	logic [`MAX_MUTE_W-1:0] max_mute_q;
	logic [`SYNC_W-1:0]     sync_q;

	wire apb_access = psel & penable & ~pready;
	wire wr_en      = psel & penable & pready & pwrite;
	wire hit_ctrl   = (paddr == `ADDR_CTRL);
	wire hit_max    = (paddr == `ADDR_MAX_MUTE);
	wire hit_sync   = (paddr == `ADDR_SYNC_TIME);
	wire hit_stat   = (paddr == `ADDR_STATUS);
	wire hit_any    = hit_ctrl | hit_max | hit_sync | hit_stat;

	wire run      = ctrl_q[`CTRL_RUN_BIT];
	wire ovr_dual = ctrl_q[`CTRL_OVR_DUAL];
	muting_pkg::mute_mode_t mode;
	assign mode = muting_pkg::mute_mode_t'(ctrl_q[`CTRL_MODE_BIT]);

	logic run_prev_q;
	wire  run_rise = run & ~run_prev_q;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ctrl_q     <= `CTRL_RESET;
			max_mute_q <= `MAX_MUTE_RESET;
			sync_q     <= `SYNC_RESET;
			run_prev_q <= 1'b0;
		end
		else
		begin
			run_prev_q <= run;
			if (wr_en && hit_ctrl)
				ctrl_q <= pwdata[2:0];
			if (wr_en && hit_max)
				max_mute_q <= pwdata[`MAX_MUTE_W-1:0];
			if (wr_en && hit_sync)
				sync_q <= pwdata[`SYNC_W-1:0];
		end
	end

	// Monitor core
	muting_pkg::mute_state_t state_q;
	muting_pkg::mute_state_t state_d;
	logic [`SYNC_W-1:0]      sync_cnt_q;
	logic [`MUTE_CNT_W-1:0]  mute_cnt_q;
	logic                    seq_err_q;
	logic                    sync_err_q;
	logic                    oe_q;
	logic                    mute_q;
	logic                    fault_q;

	wire lc_ok = &guard_q.light_curtain_input_pair;
	wire disc  = guard_q.lc_discrepancy |
		(ovr_dual & guard_q.ovr_discrepancy);
	wire fwd   = (mode == muting_pkg::SEQ_FORWARD);
	wire exit_any = sens_q.exit_first | sens_q.exit_second;
	wire all_off  = ~sens_q.entry_first & ~sens_q.entry_second &
		~(fwd & exit_any);

	wire [2:0] on_count = {2'h0, sens_q.entry_first} +
		{2'h0, sens_q.entry_second} + {2'h0, sens_q.exit_first} +
		{2'h0, sens_q.exit_second};

	wire [`MUTE_CNT_W-1:0] mute_limit =
		`MUTE_CNT_W'(max_mute_q) * `MUTE_CNT_W'(STEP_SCANS);
	wire mute_expired = (max_mute_q != '0) && (mute_cnt_q >= mute_limit);
	wire sync_expired = (sync_cnt_q >= sync_q);

	wire par_end = ~sens_q.entry_first | ~sens_q.entry_second;
	wire fwd_end = (on_count < 3'h2) | ~sens_q.valid |
		(sens_prev_q.exit_first & ~sens_q.exit_first);
	// sensors, limit and discrepancy end muting
	wire mute_end = (fwd ? fwd_end : par_end) | mute_expired | disc;

	// wrong first sensor or both together
	wire armed_bad = sens_q.entry_second | (fwd & exit_any);
	wire pair_bad  = fwd & exit_any;
	wire start_ok  = lc_ok & ~disc;

	logic set_seq;
	logic set_sync;
	logic clr_sync;

	always_comb
	begin
		state_d  = state_q;
		set_seq  = 1'b0;
		set_sync = 1'b0;
		clr_sync = 1'b0;
		case (state_q)
			muting_pkg::WAIT_CLEAR:
				if (all_off)
					state_d = muting_pkg::ARMED;
			muting_pkg::ARMED:
				if (armed_bad)
				begin
					set_seq = 1'b1;
					state_d = muting_pkg::WAIT_CLEAR;
				end
				else if (sens_q.entry_first)
					state_d = muting_pkg::SYNCING;
			muting_pkg::SYNCING:
				if (!sens_q.entry_first)
					state_d = muting_pkg::WAIT_CLEAR;
				else if (sens_q.entry_second && pair_bad)
				begin
					set_seq = 1'b1;
					state_d = muting_pkg::WAIT_CLEAR;
				end
				else if (sens_q.entry_second && start_ok)
				begin
					clr_sync = 1'b1;
					state_d  = muting_pkg::MUTING;
				end
				else if (sens_q.entry_second)
					state_d = muting_pkg::WAIT_CLEAR;
				else if (sync_expired)
				begin
					set_sync = 1'b1;
					state_d  = muting_pkg::WAIT_CLEAR;
				end
			muting_pkg::MUTING:
				if (mute_end)
					state_d = muting_pkg::WAIT_CLEAR;
			muting_pkg::HALTED:
				state_d = muting_pkg::WAIT_CLEAR;
			default:
				state_d = muting_pkg::WAIT_CLEAR;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst || !run)
			state_q <= muting_pkg::HALTED;
		else if (eval_q)
			state_q <= state_d;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			sync_cnt_q <= '0;
			mute_cnt_q <= '0;
		end
		else if (eval_q)
		begin
			if (state_q == muting_pkg::SYNCING && !sync_expired)
				sync_cnt_q <= sync_cnt_q + `SYNC_W'(1);
			else if (state_q != muting_pkg::SYNCING)
				sync_cnt_q <= `SYNC_W'(1);
			if (state_q == muting_pkg::MUTING && !mute_expired)
				mute_cnt_q <= mute_cnt_q + `MUTE_CNT_W'(1);
			else if (state_q != muting_pkg::MUTING)
				mute_cnt_q <= `MUTE_CNT_W'(1);
		end
	end

	// Error flags; a set wins over a same-cycle clear
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			seq_err_q  <= 1'b0;
			sync_err_q <= 1'b0;
		end
		else
		begin
			if (eval_q && run && set_seq)
				seq_err_q <= 1'b1;
			else if (run_rise)
				seq_err_q <= 1'b0;
			if (eval_q && run && set_sync)
				sync_err_q <= 1'b1;
			else if (eval_q && run && clr_sync)
				sync_err_q <= 1'b0;
		end
	end

	wire muting_now = (state_q == muting_pkg::MUTING);

	// Outputs; curtain state comes from the scan-held image, as does the state, so muting end and
	// curtain loss act together
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			oe_q    <= 1'b0;
			mute_q  <= 1'b0;
			fault_q <= 1'b0;
		end
		else
		begin
			mute_q  <= run & muting_now & ~disc;
			oe_q    <= run & ~disc & (muting_now | lc_ok);
			fault_q <= disc | ((seq_err_q | sync_err_q) & ~lc_ok);
		end
	end

	assign output_enable  = oe_q;
	assign muting_status  = mute_q;
	assign sequence_error = seq_err_q;
	assign sync_error     = sync_err_q;
	assign fault_present  = fault_q;

	// APB slave: one wait state, registered answer
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] status_word;

	always_comb
	begin
		status_word = 32'h0;
		status_word[`ST_OUT_EN]   = oe_q;
		status_word[`ST_MUTING]   = mute_q;
		status_word[`ST_SEQ_ERR]  = seq_err_q;
		status_word[`ST_SYNC_ERR] = sync_err_q;
		status_word[`ST_LC_DISC]  = guard_q.lc_discrepancy;
		status_word[`ST_OVR_DISC] = guard_q.ovr_discrepancy;
		status_word[`ST_FAULT]    = fault_q;
		status_word[`ST_STATE_LSB +: 3] = state_q;
	end

	wire [31:0] rd_mux =
		hit_ctrl ? {29'h0, ctrl_q} :
		hit_max  ? {24'h0, max_mute_q} :
		hit_sync ? {16'h0, sync_q} :
		hit_stat ? status_word : 32'h0;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			prdata_q  <= 32'h0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= apb_access;
			pslverr_q <= apb_access & ~hit_any;
			if (apb_access && !pwrite)
				prdata_q <= rd_mux;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

endmodule

// >>> dv/muting_sequence_monitor_assertions.sv
/* Port checker for the muting sequence monitor.
   Assumes a bind onto the monitor and one clock domain. */
`timescale 1ns/10ps
module muting_sequence_monitor_assertions #(
	parameter int SCAN_CYCLES = 4,
	parameter int STEP_SCANS = 3
)(
	input wire logic	mclk,
	input wire logic	srst,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [11:0]	paddr,
	input wire logic	pready,
	input wire logic	pslverr,
	input wire logic	entry_sensor_first,
	input wire logic	exit_sensor_first,
	input wire logic	exit_sensor_second,
	input wire logic [1:0]	light_curtain_input_pair,
	input wire logic	lc_discrepancy_err,
	input wire logic	output_enable,
	input wire logic	muting_status,
	input wire logic	sequence_error,
	input wire logic	sync_error
);
	logic [7:0]	since_ctrl_q;
	logic [7:0]	since_ctrl_d;
	logic		ctrl_wr;

	assign ctrl_wr = psel && penable && pwrite && pready && paddr == 12'h000;
	// Saturates so an old write never looks recent
	assign since_ctrl_d = ctrl_wr ? 8'h00 :
		since_ctrl_q + {7'h00, since_ctrl_q != 8'hFF};
	always_ff @(posedge mclk)
	begin
		if (srst)
			since_ctrl_q <= 8'hFF;
		else
			since_ctrl_q <= since_ctrl_d;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	chk_mute_keeps_oe:
	assert property (muting_status |-> output_enable)
		else $error("muting without output enable");
	chk_disc_drops_all:
	assert property (lc_discrepancy_err [*8] |=> ##1
		(!output_enable && !muting_status))
		else $error("discrepancy left output on");
	chk_blocked_drops_oe:
	assert property ((light_curtain_input_pair != 2'h3 && !muting_status)
		[*8] |=> ##1 !output_enable)
		else $error("obstructed curtain left output on");
	chk_few_sensors_end:
	assert property ((!entry_sensor_first && !exit_sensor_first &&
		!exit_sensor_second) [*8] |=> ##1 !muting_status)
		else $error("muting kept with sensors clear");
	chk_seq_clear_run:
	assert property ($fell(sequence_error) |-> since_ctrl_q < 8'd16)
		else $error("sequence error cleared without run change");
	chk_sync_clear_mute:
	assert property ($fell(sync_error) && since_ctrl_q > 8'd16 |->
		##[0:2] muting_status)
		else $error("sync error cleared without muting");
	chk_apb_one_wait:
	assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered next cycle");
	chk_unmapped_err:
	assert property (psel && penable && !pready && paddr > 12'h00C |=>
		pslverr)
		else $error("unmapped access without slave error");

	cover property ($rose(muting_status));
	cover property ($rose(sequence_error));
	cover property ($rose(sync_error));
endmodule

bind muting_sequence_monitor muting_sequence_monitor_assertions #(
	.SCAN_CYCLES(SCAN_CYCLES), .STEP_SCANS(STEP_SCANS)) u_chk (.mclk,
	.srst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
	.entry_sensor_first, .exit_sensor_first, .exit_sensor_second,
	.light_curtain_input_pair, .lc_discrepancy_err, .output_enable,
	.muting_status, .sequence_error, .sync_error);

// >>> dv/sensor_rig.sv
/* Muting sensor rig: a workpiece passing two entry beams.
   Assumes a bench that loads levels and pulses start. */
`timescale 1ns/10ps
module sensor_rig (
	input wire logic		mclk,
	input wire logic		load,
	input muting_pkg::sensor_set_t	preset,
	input wire logic		start,
	input wire logic		swap,
	input wire logic [7:0]		gap,
	output muting_pkg::sensor_set_t	pins
);
	muting_pkg::sensor_set_t	pins_q = 5'h01;
	logic [7:0]			left_q = 8'h00;

	assign pins = pins_q;
	// Second beam follows the first after gap clocks
	always_ff @(posedge mclk)
	begin
		if (load)
			pins_q <= preset;
		if (start)
		begin
			pins_q.entry_first <= !swap;
			pins_q.entry_second <= swap;
			left_q <= gap;
		end
		else if (left_q != 8'h00)
		begin
			left_q <= left_q - 8'h01;
			if (left_q == 8'h01)
			begin
				pins_q.entry_first <= 1'h1;
				pins_q.entry_second <= 1'h1;
			end
		end
	end
endmodule

// >>> dv/muting_sequence_monitor_bench.sv
/* Self-checking bench for the muting sequence monitor.
   Assumes the sensor rig and the bound port checker. */
`timescale 1ns/10ps
module muting_sequence_monitor_bench;
	localparam int SCAN = 4;
	localparam int SYNC = 5;
	localparam int KS[4] = '{1, 2, 3, 8};
	logic		mclk = 1'h0;
	logic		srst = 1'h1;
	logic		psel = 1'h0;
	logic		penable = 1'h0;
	logic		pwrite = 1'h0;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h0;
	logic [31:0]	prdata;
	logic		pready;
	logic		pslverr;
	logic [1:0]	light_curtain_input_pair = 2'h3;
	logic		lc_discrepancy_err = 1'h0;
	logic		ovr_discrepancy_err = 1'h0;
	logic		output_enable;
	logic		muting_status;
	logic		sequence_error;
	logic		sync_error;
	logic		fault_present;
	logic		load = 1'h0;
	logic		start = 1'h0;
	logic		swap = 1'h0;
	logic [7:0]	gap = 8'h00;
	logic [31:0]	rd;
	logic		err;
	logic		s;
	logic [2:0]	e;
	int		k;
	int		failures = 0;
	int		check_count = 0;
	int		cycles = 0;
	muting_pkg::sensor_set_t	preset = 5'h01;
	muting_pkg::sensor_set_t	pins;

	muting_sequence_monitor #(.SCAN_CYCLES(SCAN), .STEP_SCANS(3))
		u_muting_sequence_monitor (.mclk, .srst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.entry_sensor_first(pins.entry_first),
		.entry_sensor_second(pins.entry_second),
		.exit_sensor_first(pins.exit_first),
		.exit_sensor_second(pins.exit_second),
		.sensor_status_valid(pins.valid), .light_curtain_input_pair,
		.lc_discrepancy_err, .ovr_discrepancy_err, .output_enable,
		.muting_status, .sequence_error, .sync_error,
		.fault_present);
	sensor_rig u_sensor_rig (.mclk, .load, .preset, .start, .swap, .gap,
		.pins);

	always #50 mclk = ~mclk;

	task final_report();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			failures++;
			final_report();
		end
	end

	task chk(string n, logic [31:0] x, logic [31:0] y);
		check_count++;
		if (y !== x)
		begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, x, y);
		end
	endtask

	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do
			@(posedge mclk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task settle();
		repeat (12) @(posedge mclk);
	endtask

	task put(logic [4:0] v);
		preset <= muting_pkg::sensor_set_t'(v);
		load <= 1'h1;
		@(posedge mclk);
		load <= 1'h0;
	endtask

	// Run toggle clears the sticky order fault
	task restart(logic [31:0] c);
		apb(1'h1, 12'h000, 32'h0);
		apb(1'h1, 12'h000, c);
		light_curtain_input_pair <= 2'h3;
		put(5'h01);
		settle();
	endtask

	task pass(int n, logic sw);
		start <= 1'h1;
		swap <= sw;
		gap <= 8'(n * SCAN);
		@(posedge mclk);
		start <= 1'h0;
		repeat (n * SCAN + 12) @(posedge mclk);
	endtask

	function logic [2:0] expect_start(int n, logic sw);
		if (sw)
			return 3'h2;
		if (n >= SYNC)
			return 3'h1;
		return 3'h4;
	endfunction

	initial
	begin
		void'($urandom(26424));
		repeat (2) @(posedge mclk);
		srst <= 1'h0;
		@(posedge mclk);
		chk("oe_reset", 32'h0, output_enable);
		apb(1'h0, 12'h004, 32'h0);
		chk("max_mute", 32'h78, rd);
		apb(1'h0, 12'h008, 32'h0);
		chk("sync_time", 32'hBB8, rd);
		apb(1'h0, 12'h010, 32'h0);
		chk("unmapped", 32'h1, err);
		apb(1'h1, 12'h008, SYNC);
		apb(1'h1, 12'h004, 32'h0);
		$display("test registers finished");
		for (int i = 0; i < 8; i++)
		begin
			k = (i == 0) ? 1 : KS[$urandom_range(3)];
			s = (i != 0) && ($urandom_range(3) == 0);
			e = expect_start(k, s);
			restart(32'h1);
			chk("seq_clear", 32'h0, sequence_error);
			chk("oe_clear", 32'h1, output_enable);
			pass(k, s);
			chk("muting", e[2], muting_status);
			chk("seq_err", e[1], sequence_error);
			if (!s)
				chk("sync_err", e[0], sync_error);
			light_curtain_input_pair <= 2'h0;
			settle();
			chk("oe_blocked", e[2], output_enable);
			if (e[2])
			begin
				put(5'h09);
				settle();
				chk("mute_end", 32'h0, muting_status);
				chk("oe_end", 32'h0, output_enable);
			end
			$display("test pass %0d finished", i);
		end
		restart(32'h1);
		apb(1'h1, 12'h004, 32'h2);
		pass(2, 1'h0);
		chk("mute_on", 32'h1, muting_status);
		repeat (36) @(posedge mclk);
		chk("mute_limit", 32'h0, muting_status);
		chk("oe_limit", 32'h1, output_enable);
		apb(1'h1, 12'h004, 32'h0);
		restart(32'h1);
		pass(2, 1'h0);
		lc_discrepancy_err <= 1'h1;
		settle();
		chk("mute_disc", 32'h0, muting_status);
		chk("oe_disc", 32'h0, output_enable);
		chk("fault_disc", 32'h1, fault_present);
		lc_discrepancy_err <= 1'h0;
		restart(32'h5);
		ovr_discrepancy_err <= 1'h1;
		settle();
		chk("oe_ovr_dual", 32'h0, output_enable);
		restart(32'h1);
		chk("oe_ovr_single", 32'h1, output_enable);
		ovr_discrepancy_err <= 1'h0;
		$display("test limits finished");
		restart(32'h3);
		put(5'h19);
		settle();
		chk("same_scan", 32'h1, sequence_error);
		light_curtain_input_pair <= 2'h0;
		settle();
		chk("oe_seq_blk", 32'h0, output_enable);
		chk("fault_seq", 32'h1, fault_present);
		restart(32'h3);
		put(5'h03);
		pass(2, 1'h0);
		chk("exit_on", 32'h1, sequence_error);
		restart(32'h3);
		pass(2, 1'h0);
		chk("fwd_mute", 32'h1, muting_status);
		put(5'h1E);
		settle();
		chk("invalid", 32'h0, muting_status);
		$display("test forward finished");
		final_report();
	end
endmodule
